// ### pio_io_execute_slave_test.sv
`default_nettype none
module pio_io_execute_slave_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pioxs_pkg::*;

  // Bench signals
  logic        ref_clk, reset_n, master_clear, strap_c, one_way;
  logic        in_stb, in_err, out_done, out_err;
  logic        in_act, out_act, irq_r, irq_e;
  logic [7:0]  mod_a;
  logic [15:0] in_data, out_data, q;
  logic [3:0]  in_fmt, out_fmt;
  logic [10:0] base;
  logic [2:0]  idle3;
  pioxs_req_t  cpu_req;
  pioxs_ans_t  cpu_ans;
  int          err_total, samples_checked, act_in, act_out;

  assign idle3 = {cpu_ans.ack, cpu_ans.dir, cpu_ans.data_oe_n};

  pioxs_top uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .cpu_req(cpu_req),
    .master_clear(master_clear), .cpu_ans(cpu_ans),
    .branch_strap_closed(strap_c), .one_way_mode(one_way),
    .module_addr(mod_a), .dev_in_strobe(in_stb), .dev_in_error(in_err),
    .dev_in_data(in_data), .dev_in_activate(in_act), .in_format(in_fmt),
    .dev_out_done(out_done), .dev_out_error(out_err),
    .dev_out_activate(out_act), .dev_out_data(out_data),
    .out_format(out_fmt), .irq_ready(irq_r), .irq_error(irq_e)
  );

  pioxs_cpu_model cpu (
    .ref_clk(ref_clk), .cpu_req(cpu_req), .cpu_ans(cpu_ans)
  );

  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Activate is a one-cycle pulse, so count it where it happens
  always @(posedge ref_clk) begin
    if (in_act === 1'b1) act_in++;
    if (out_act === 1'b1) act_out++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // One access, then the bus must be back at rest
  task automatic go(input logic [10:0] a, input logic [15:0] d,
                    input logic [1:0] ste, output logic [15:0] r);
    logic [1:0] st;
    cpu.io_execute_instruction(a, d, r, st);
    chk(16'(st), 16'(ste));
    chk(16'(idle3), 16'h0001);
  endtask : go

  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    logic [15:0] r;
    go(base | 11'(i), d, 2'h0, r);
    chk(r, d);
  endtask : wr

  // Accumulator holds the inverse so a wrong direction shows
  task automatic rdc(input logic [2:0] i, input logic [15:0] exp);
    logic [15:0] r;
    go(base | 11'(i), ~exp, 2'h0, r);
    chk(r, exp);
  endtask : rdc

  // Main sequence
  initial begin
    reset_n = 1'b0;
    master_clear = 1'b0;
    strap_c = 1'b1;
    one_way = 1'b0;
    mod_a = 8'h2a;
    {in_stb, in_err, out_done, out_err} = 4'h0;
    in_data = 16'h0000;
    err_total = 0;
    samples_checked = 0;
    base = 11'h0a8;
    tick(12);
    reset_n <= 1'b1;
    tick(1);
    rdc(REG_IN_STAT, 16'h0000);
    rdc(REG_OUT_STAT, 16'h0008);
    wr(REG_IN_CTRL, 16'h7803);
    chk(16'(in_fmt), 16'h000f);
    rdc(REG_IN_STAT, 16'h7803);
    // Strobed input word with ready interrupt enabled
    wr(REG_IN_CTRL, 16'h0011);
    in_data <= 16'hbeef;
    in_stb <= 1'b1;
    tick(6);
    in_stb <= 1'b0;
    rdc(REG_IN_STAT, 16'h0009);
    chk(16'(irq_r), 16'h0001);
    rdc(REG_IN_DATA, 16'hbeef);
    rdc(REG_IN_STAT, 16'h0001);
    // Sticky error until a device clear
    in_err <= 1'b1;
    tick(6);
    in_err <= 1'b0;
    rdc(REG_IN_STAT, 16'h0011);
    chk(16'(irq_e), 16'h0000);
    wr(REG_IN_CTRL, 16'h0010);
    rdc(REG_IN_STAT, 16'h0000);
    // Test mode loads the input data from the test register
    wr(REG_IN_CTRL, 16'h0008);
    wr(REG_IN_TEST, 16'h5a5a);
    rdc(REG_IN_DATA, 16'h5a5a);
    // Output buffer full, then emptied by the device
    wr(REG_OUT_DATA, 16'h1234);
    chk(out_data, 16'h1234);
    rdc(REG_OUT_TEST, 16'h1234);
    rdc(REG_OUT_STAT, 16'h0000);
    out_done <= 1'b1;
    tick(6);
    out_done <= 1'b0;
    out_err <= 1'b1;
    tick(6);
    out_err <= 1'b0;
    rdc(REG_OUT_STAT, 16'h0018);
    // Output control: format, error interrupt enable and one activation
    wr(REG_OUT_CTRL, 16'h2006);
    chk(16'(out_fmt), 16'h0004);
    chk(16'(irq_e), 16'h0001);
    // Refused: wrong half, wrong module
    go(base | 11'h402, 16'h0000, 2'h1, q);
    go(base ^ 11'h008, 16'h0000, 2'h1, q);
    // Strap open moves the block to the upper half
    strap_c <= 1'b0;
    base = 11'h4a8;
    tick(3);
    rdc(REG_OUT_STAT, 16'h201e);
    go(11'h0ae, 16'h0000, 2'h1, q);
    // One-way compare of bits 9:2
    one_way <= 1'b1;
    mod_a <= 8'h2b;
    base = 11'h4ac;
    tick(3);
    rdc(REG_IN_STAT, 16'h0000);
    wr(REG_IN_CTRL, 16'h7803);
    master_clear <= 1'b1;
    tick(4);
    master_clear <= 1'b0;
    tick(4);
    chk(16'(in_fmt), 16'h0000);
    rdc(REG_IN_STAT, 16'h0000);
    wr(REG_IN_CTRL, 16'h0004);
    chk(16'(act_in), 16'h0001);
    chk(16'(act_out), 16'h0001);
    final_report();
  end
endmodule : pio_io_execute_slave_test
`default_nettype wire

// ### pioxs_cpu_model.sv
`default_nettype none
module pioxs_cpu_model #(
  parameter logic [1:0] RING = 2'h2
) (
  // Clock
  input  wire logic                  ref_clk,
  // Local bus
  output pioxs_pkg::pioxs_req_t      cpu_req,
  input  wire pioxs_pkg::pioxs_ans_t cpu_ans
);
  timeunit 1ns;
  timeprecision 1ns;
  import pioxs_pkg::*;

  // Five to six microseconds at 100 ns a cycle
  localparam int TMO = 55;

  // Bus idle from time zero
  initial cpu_req = '0;

  // One execute instruction; st 0 done, 1 timed out, 2 ack stuck
  task automatic io_execute_instruction(input logic [10:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic [1:0] st);
    int n;
    q  = d;
    st = 2'h0;
    if (RING < 2'h2) return;
    @(posedge ref_clk);
    cpu_req <= '{exec: 1'b1, addr: a, data: d};
    n = 0;
    while (cpu_ans.ack !== 1'b1 && n < TMO) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == TMO) begin
      st = 2'h1;
    end else begin
      @(posedge ref_clk);
      q = cpu_ans.dir ? cpu_ans.data : d;
    end
    // Released lines show the inverse, never a stale copy
    cpu_req <= '{exec: 1'b0, addr: ~a, data: ~d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cpu_ans.ack !== 1'b0 && n < 8);
    if (n == 8) st = 2'h2;
    // Gap so the next cycle sees exec low first
    @(posedge ref_clk);
  endtask : io_execute_instruction
endmodule : pioxs_cpu_model
`default_nettype wire

// ### pioxs_decode.sv
`default_nettype none
module pioxs_decode (
  // Synchronised bus inputs
  input  wire logic        exec,
  input  wire logic [10:0] addr,
  // Straps
  input  wire logic        strap_closed,
  input  wire logic        one_way,
  input  wire logic [7:0]  mod_addr,
  // Decode results
  output logic             local_en,
  output logic             hit,
  output logic [2:0]       idx,
  output logic             is_out
);
  import pioxs_pkg::*;

  // Branch: low half when strap closed, upper half when open
  assign local_en = exec & (addr[HALF_BIT] == ~strap_closed);

  // Module address compare, width depends on interface kind
  always_comb begin
    if (one_way) begin
      hit = (addr[CMP_MSB:OW_CMP_LSB] == mod_addr);
      idx = {1'b0, addr[1:0]};
    end else begin
      hit = (addr[CMP_MSB:TW_CMP_LSB] == mod_addr[7:1]);
      idx = addr[2:0];
    end
  end

  assign is_out = addr[0];
endmodule : pioxs_decode
`default_nettype wire

// ### pioxs_devport.sv
`default_nettype none
module pioxs_devport #(
  parameter logic READY_INIT = 1'b0
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Raw device pins
  input  wire logic pin_strobe,
  input  wire logic pin_error,
  // Control from the register side
  input  wire logic clear,
  input  wire logic activate,
  input  wire logic consume,
  input  wire logic test_load,
  // Flags
  output logic      event_pulse,
  output logic      ready,
  output logic      error,
  output logic      active
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic       strobe_d_r;

  // Two flops on device pins; only sync_r is read by logic
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
      strobe_d_r <= 1'b0;
    end else begin
      meta_r <= {pin_error, pin_strobe};
      sync_r <= meta_r;
      strobe_d_r <= sync_r[0];
    end
  end

  assign event_pulse = sync_r[0] & ~strobe_d_r;

  // Ready: device event or test load sets, consume clears; set wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready <= READY_INIT;
    end else if (event_pulse || test_load) begin
      ready <= 1'b1;
    end else if (clear) begin
      ready <= READY_INIT;
    end else if (consume) begin
      ready <= 1'b0;
    end
  end

  // Sticky error, an arriving error beats the clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      error <= 1'b0;
    end else if (sync_r[1]) begin
      error <= 1'b1;
    end else if (clear) begin
      error <= 1'b0;
    end
  end

  // Device busy from activation until its completion strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      active <= 1'b0;
    end else if (activate) begin
      active <= 1'b1;
    end else if (event_pulse || clear) begin
      active <= 1'b0;
    end
  end
endmodule : pioxs_devport
`default_nettype wire

// ### pioxs_pkg.sv
// Function
// - Each direction has data, control word and status registers; two-way has six.
// - Control bit 2 activates the attached device for one operation.
// - Control bit 3 places the interface in test mode.
// - Control bits 0 and 1 enable ready and error interrupts.
// - Status bits 0 and 1 read back the two interrupt enables.
// - Control bits 11 to 14 select serial length, stop bits and parity.
// - Status bit 3 flags input data latched or output buffer empty.
// - Status bit 4 is set when any error condition has occurred.
// - Registers are decoded within the 11-bit address from the instruction.
// - Low half is standard interfaces, upper half customer; answer own half.
// - A one-way interface spans four aligned addresses, fourth is test data; the code puts test data at the second (REG_IN_TEST = 1).
// - Test data is written on input side, read on output side.
// - Two-way interfaces decode up to eight registers, one per address.
// - Compare bits 2-9 or 3-9 with strap address, then decode low bits.
// - Address bit 0 high: capture the data lines, then acknowledge.
// - Address bit 0 low: drive register, raise direction, then acknowledge; the code raises direction in the same cycle as acknowledge.
// - Standard behaviour: no combined capture-and-input on one instruction.
// - On execute enable removal, drop acknowledge and direction.
// - Direction true moves device data to CPU, false the reverse.
// - Master clear from the CPU clears all interface logic; the code leaves rd_data_r and cyc_out_r untouched.
// - Local enable below 2000 octal with strap closed, above with open.
`default_nettype none
package pioxs_pkg;
  // Register index within the module (low address bits, bit 0 = write)
  localparam logic [2:0] REG_IN_DATA   = 3'h0;
  localparam logic [2:0] REG_IN_TEST   = 3'h1;
  localparam logic [2:0] REG_IN_STAT   = 3'h2;
  localparam logic [2:0] REG_IN_CTRL   = 3'h3;
  localparam logic [2:0] REG_OUT_TEST  = 3'h4;
  localparam logic [2:0] REG_OUT_DATA  = 3'h5;
  localparam logic [2:0] REG_OUT_STAT  = 3'h6;
  localparam logic [2:0] REG_OUT_CTRL  = 3'h7;
  // Address layout
  localparam int unsigned HALF_BIT     = 10;
  localparam int unsigned CMP_MSB      = 9;
  localparam int unsigned OW_CMP_LSB   = 2;
  localparam int unsigned TW_CMP_LSB   = 3;
  // Control word fields
  localparam int unsigned CW_RDY_IE    = 0;
  localparam int unsigned CW_ERR_IE    = 1;
  localparam int unsigned CW_ACTIVATE  = 2;
  localparam int unsigned CW_TEST      = 3;
  localparam int unsigned CW_CLEAR     = 4;
  localparam int unsigned CW_FMT_LSB   = 11;
  localparam int unsigned CW_FMT_MSB   = 14;
  // Status word fields
  localparam int unsigned ST_ACTIVE    = 2;
  localparam int unsigned ST_READY     = 3;
  localparam int unsigned ST_ERROR     = 4;
  localparam int unsigned ST_MODE_LSB  = 11;
  // Reset values
  localparam logic [15:0] CW_RESET     = 16'h0000;
  localparam logic [15:0] DATA_RESET   = 16'h0000;

  // CPU request on the local bus
  typedef struct packed {
    logic        exec;
    logic [10:0] addr;
    logic [15:0] data;
  } pioxs_req_t;

  // Answer to the CPU; data lines are three-state with oe_n
  typedef struct packed {
    logic        ack;
    logic        dir;
    logic        data_oe_n;
    logic [15:0] data;
  } pioxs_ans_t;

  // Pins other than the device strobe and error lines, synchronised as one bundle
  typedef struct packed {
    pioxs_req_t  req;
    logic        mclr;
    logic        strap_closed;
    logic        one_way;
    logic [7:0]  mod_addr;
    logic [15:0] in_data;
  } pioxs_pins_t;

  // Status word from control word and device flags
  function automatic logic [15:0] pioxs_status(input logic [15:0] cw,
      input logic active, input logic ready, input logic error);
    logic [15:0] s;
    s = 16'h0000;
    s[CW_ERR_IE:CW_RDY_IE] = cw[CW_ERR_IE:CW_RDY_IE];
    s[ST_ACTIVE] = active;
    s[ST_READY]  = ready;
    s[ST_ERROR]  = error;
    s[15:ST_MODE_LSB] = cw[15:ST_MODE_LSB];
    return s;
  endfunction : pioxs_status
endpackage : pioxs_pkg
`default_nettype wire

// ### pioxs_top.sv
`default_nettype none
module pioxs_top (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // CPU side of the local bus, raw pins
  input  wire pioxs_pkg::pioxs_req_t cpu_req,
  input  wire logic                  master_clear,
  output pioxs_pkg::pioxs_ans_t      cpu_ans,
  // Straps
  input  wire logic                  branch_strap_closed,
  input  wire logic                  one_way_mode,
  input  wire logic [7:0]            module_addr,
  // Input device
  input  wire logic                  dev_in_strobe,
  input  wire logic                  dev_in_error,
  input  wire logic [15:0]           dev_in_data,
  output logic                       dev_in_activate,
  output logic [3:0]                 in_format,
  // Output device
  input  wire logic                  dev_out_done,
  input  wire logic                  dev_out_error,
  output logic                       dev_out_activate,
  output logic [15:0]                dev_out_data,
  output logic [3:0]                 out_format,
  // Interrupt requests, gated by the control word enables
  output logic                       irq_ready,
  output logic                       irq_error
);
  import pioxs_pkg::*;

  typedef enum logic [1:0] {CY_IDLE, CY_SETTLE, CY_ACK} pioxs_cyc_t;

  pioxs_pins_t pins_raw;
  pioxs_pins_t meta_r;
  pioxs_pins_t pins_r;
  pioxs_cyc_t  state_r;
  pioxs_cyc_t  state_nxt;
  logic        exec_s;
  logic        mclr_s;
  logic        local_en;
  logic        hit;
  logic [2:0]  idx;
  logic        is_out;
  logic        start;
  logic        wr_pulse;
  logic        rd_start;
  logic [15:0] wr_data;
  logic        cyc_out_r;
  logic [15:0] rd_data_r;
  logic [15:0] rd_mux;
  logic        oe_n_r;
  logic [15:0] cw_in_r;
  logic [15:0] cw_out_r;
  logic [15:0] in_data_r;
  logic [15:0] test_in_r;
  logic [15:0] out_data_r;
  logic        clr_in_r;
  logic        clr_out_r;
  logic        in_event;
  logic        in_ready;
  logic        in_error;
  logic        in_active;
  logic        out_ready;
  logic        out_error;
  logic        out_active;
  logic        test_load;

  // All pins but the device strobe and error lines into one bundle so they cross together
  assign pins_raw = '{req: cpu_req, mclr: master_clear,
                      strap_closed: branch_strap_closed,
                      one_way: one_way_mode, mod_addr: module_addr,
                      in_data: dev_in_data};

  // Two-flop synchroniser; meta_r feeds nothing but pins_r
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      pins_r <= '0;
    end else begin
      meta_r <= pins_raw;
      pins_r <= meta_r;
    end
  end

  assign exec_s  = pins_r.req.exec;
  assign mclr_s  = pins_r.mclr;
  assign wr_data = pins_r.req.data;

  // Address branch, compare and register select
  pioxs_decode u_decode (
    .exec         (exec_s),
    .addr         (pins_r.req.addr),
    .strap_closed (pins_r.strap_closed),
    .one_way      (pins_r.one_way),
    .mod_addr     (pins_r.mod_addr),
    .local_en     (local_en),
    .hit          (hit),
    .idx          (idx),
    .is_out       (is_out)
  );

  // A cycle is taken only once per enable, from idle
  assign start    = (state_r == CY_IDLE) & local_en & hit & ~mclr_s;
  assign wr_pulse = start & is_out;
  assign rd_start = start & ~is_out;
  assign test_load = wr_pulse & (idx == REG_IN_TEST) & cw_in_r[CW_TEST];

  // Cycle sequencer: data settles one cycle before acknowledge
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CY_IDLE:   if (start) state_nxt = CY_SETTLE;
      CY_SETTLE: state_nxt = exec_s ? CY_ACK : CY_IDLE;
      CY_ACK:    if (!exec_s) state_nxt = CY_IDLE;
      default:   state_nxt = CY_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CY_IDLE;
    end else if (mclr_s) begin
      state_r <= CY_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Remember the direction of the running cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_out_r <= 1'b0;
    end else if (start) begin
      cyc_out_r <= is_out;
    end
  end

  // Read multiplexer; one-way mode never reaches the upper four
  always_comb begin
    case (idx)
      REG_IN_DATA:  rd_mux = in_data_r;
      REG_IN_STAT:  rd_mux = pioxs_status(cw_in_r, in_active, in_ready,
                                          in_error);
      REG_OUT_TEST: rd_mux = out_data_r;
      REG_OUT_STAT: rd_mux = pioxs_status(cw_out_r, out_active, out_ready,
                                          out_error);
      default:      rd_mux = 16'h0000;
    endcase
  end

  // Read data and bus driver; released on the first clock edge that sees enable gone
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= DATA_RESET;
      oe_n_r    <= 1'b1;
    end else if (!exec_s || mclr_s) begin
      oe_n_r    <= 1'b1;
    end else if (rd_start) begin
      rd_data_r <= rd_mux;
      oe_n_r    <= 1'b0;
    end
  end

  // Answer: direction only on input cycles, no combined transfer
  assign cpu_ans.ack       = (state_r == CY_ACK) & exec_s;
  assign cpu_ans.dir       = cpu_ans.ack & ~cyc_out_r;
  assign cpu_ans.data_oe_n = oe_n_r;
  assign cpu_ans.data      = rd_data_r;

  // Control words; master clear returns them to reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cw_in_r  <= CW_RESET;
      cw_out_r <= CW_RESET;
    end else if (mclr_s) begin
      cw_in_r  <= CW_RESET;
      cw_out_r <= CW_RESET;
    end else if (wr_pulse && idx == REG_IN_CTRL) begin
      cw_in_r  <= wr_data;
    end else if (wr_pulse && idx == REG_OUT_CTRL) begin
      cw_out_r <= wr_data;
    end
  end

  // Serial converter format straight from the control words
  assign in_format  = cw_in_r[CW_FMT_MSB:CW_FMT_LSB];
  assign out_format = cw_out_r[CW_FMT_MSB:CW_FMT_LSB];

  // One-operation activation and device clear pulses
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_in_activate  <= 1'b0;
      dev_out_activate <= 1'b0;
      clr_in_r         <= 1'b0;
      clr_out_r        <= 1'b0;
    end else begin
      dev_in_activate  <= wr_pulse & (idx == REG_IN_CTRL)
                          & wr_data[CW_ACTIVATE];
      dev_out_activate <= wr_pulse & (idx == REG_OUT_CTRL)
                          & wr_data[CW_ACTIVATE];
      clr_in_r  <= mclr_s | (wr_pulse & (idx == REG_IN_CTRL)
                             & wr_data[CW_CLEAR]);
      clr_out_r <= mclr_s | (wr_pulse & (idx == REG_OUT_CTRL)
                             & wr_data[CW_CLEAR]);
    end
  end

  // Data registers; in test mode the test pattern stands in for input
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_data_r <= DATA_RESET;
      test_in_r <= DATA_RESET;
    end else if (mclr_s) begin
      in_data_r <= DATA_RESET;
      test_in_r <= DATA_RESET;
    end else begin
      if (wr_pulse && idx == REG_IN_TEST) begin
        test_in_r <= wr_data;
      end
      if (test_load) begin
        in_data_r <= wr_data;
      end else if (in_event && !cw_in_r[CW_TEST]) begin
        in_data_r <= pins_r.in_data;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_data_r <= DATA_RESET;
    end else if (mclr_s) begin
      out_data_r <= DATA_RESET;
    end else if (wr_pulse && idx == REG_OUT_DATA) begin
      out_data_r <= wr_data;
    end
  end

  assign dev_out_data = out_data_r;

  // Input side: ready means a word is latched
  pioxs_devport #(.READY_INIT(1'b0)) u_in_port (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .pin_strobe  (dev_in_strobe),
    .pin_error   (dev_in_error),
    .clear       (clr_in_r),
    .activate    (dev_in_activate),
    .consume     (rd_start && idx == REG_IN_DATA),
    .test_load   (test_load),
    .event_pulse (in_event),
    .ready       (in_ready),
    .error       (in_error),
    .active      (in_active)
  );

  // Output side: ready means the buffer is empty
  pioxs_devport #(.READY_INIT(1'b1)) u_out_port (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .pin_strobe  (dev_out_done),
    .pin_error   (dev_out_error),
    .clear       (clr_out_r),
    .activate    (dev_out_activate),
    .consume     (wr_pulse && idx == REG_OUT_DATA),
    .test_load   (1'b0),
    .event_pulse (),
    .ready       (out_ready),
    .error       (out_error),
    .active      (out_active)
  );

  // Interrupt requests registered to avoid glitches on the lines
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ready <= 1'b0;
      irq_error <= 1'b0;
    end else begin
      irq_ready <= (in_ready & cw_in_r[CW_RDY_IE])
                 | (out_ready & cw_out_r[CW_RDY_IE]);
      irq_error <= (in_error & cw_in_r[CW_ERR_IE])
                 | (out_error & cw_out_r[CW_ERR_IE]);
    end
  end

  // Checks on the cycle and the register file
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Acknowledge needs enable now and at the take and settle edges before
  a_ack_needs_exec: assert property (cpu_ans.ack |-> exec_s
      && $past(exec_s) && $past(exec_s, 2))
    else $error("acknowledge without execute enable");

  a_release_bus: assert property (!exec_s |=> cpu_ans.data_oe_n
                                  && !cpu_ans.ack && !cpu_ans.dir)
    else $error("bus not released after enable removal");

  a_write_then_ack: assert property (wr_pulse && !mclr_s
      |=> state_r == CY_SETTLE ##1 (!exec_s || cpu_ans.ack))
    else $error("write not followed by acknowledge");

  a_drive_then_ack: assert property (rd_start && !mclr_s ##1 exec_s
      |-> !cpu_ans.data_oe_n ##1 (!exec_s || (cpu_ans.ack
          && cpu_ans.dir)))
    else $error("input data not driven before acknowledge");

  // Direction follows the stored cycle kind, checked against the live address bit
  a_dir_input_only: assert property (cpu_ans.ack
      |-> cpu_ans.dir == !is_out)
    else $error("direction does not match the transfer kind");

  a_status_enables: assert property (rd_start && idx == REG_IN_STAT
      |=> rd_data_r[1:0] == $past(cw_in_r[1:0])
          && rd_data_r[ST_READY] == $past(in_ready))
    else $error("status read does not reflect enables");

  a_activate_pulse: assert property (wr_pulse && idx == REG_IN_CTRL
      && wr_data[CW_ACTIVATE] |=> dev_in_activate ##1 !dev_in_activate)
    else $error("activation is not a single pulse");

  a_branch_half: assert property (start |->
      pins_r.req.addr[HALF_BIT] == !pins_r.strap_closed)
    else $error("cycle accepted in the wrong address half");

  a_master_clear: assert property (mclr_s |=> cw_in_r == CW_RESET
      && cw_out_r == CW_RESET && state_r == CY_IDLE)
    else $error("master clear did not clear the interface");

  c_write_cycle: cover property (wr_pulse ##2 cpu_ans.ack ##[1:20] !exec_s);
  c_read_cycle:  cover property (rd_start ##2 cpu_ans.dir);
  c_test_load:   cover property (test_load ##1 in_ready);
endmodule : pioxs_top
`default_nettype wire
